// *** tfs_pkg.sv ***
// Package of constants and types for the thermal and fan status flag block
package tfs_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  TFS_IDX_STATUS_ONE = 8'h02;
    localparam logic [11:0] TFS_ADDR_STATUS    = {2'h0, TFS_IDX_STATUS_ONE, 2'h0};
    localparam logic [11:0] TFS_ADDR_MASK      = 12'h010;
    localparam logic [11:0] TFS_ADDR_IRQ       = 12'h014;
    localparam logic [11:0] TFS_ADDR_CTRL      = 12'h018;
    localparam logic [11:0] TFS_ADDR_STATE     = 12'h01C;

    // ------------------------------------------------------------
    // Field positions of the status register
    // ------------------------------------------------------------
    localparam int TFS_BIT_LOCAL_LOW   = 7;
    localparam int TFS_BIT_LOCAL_HIGH  = 6;
    localparam int TFS_BIT_SENSOR_FAIL = 5;
    localparam int TFS_BIT_SHUTDOWN    = 4;
    localparam int TFS_BIT_REMOTE_LOW  = 3;
    localparam int TFS_BIT_REMOTE_HIGH = 2;
    localparam int TFS_BIT_FAN_SLOW    = 1;
    localparam int TFS_BIT_OVERSPEED   = 0;

    // Control register bits
    localparam int TFS_CTRL_SENSOR_IE = 0;
    localparam int TFS_CTRL_SHUT_IE   = 1;
    localparam int TFS_CTRL_FAN_IE    = 2;
    localparam int TFS_CTRL_SOFT_RST  = 3;

    // ------------------------------------------------------------
    // Reset values and thresholds
    // ------------------------------------------------------------
    localparam logic [7:0] TFS_STATUS_RESET   = 8'h00;
    localparam logic [7:0] TFS_MASK_RESET     = 8'hFF;
    localparam logic [2:0] TFS_CTRL_RESET     = 3'h0;
    localparam logic [7:0] TFS_FAIL_TEMP      = 8'h80;
    localparam logic [7:0] TFS_HYST_DEG       = 8'h05;
    localparam logic [2:0] TFS_FAIL_COUNT     = 3'h5;
    localparam logic [2:0] TFS_CNT_ZERO       = 3'h0;
    localparam logic [2:0] TFS_CNT_ONE        = 3'h1;
    localparam logic [31:0] TFS_ZERO_WORD     = 32'h0000_0000;

    typedef struct packed {
        logic [7:0]  status;
        logic [7:0]  irq_pend;
        logic [7:0]  irq_mask;
        logic [2:0]  ctrl;
        logic        shut_armed;
        logic        ovs_armed;
        logic [2:0]  slow_cnt;
        logic        fan_fail;
        logic [7:0]  remote_temp;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        irq;
        logic        shutdown_n;
        logic        over_temp_n;
        logic        fan_fault_n;
        logic        alert_n;
    } tfs_state_s;

endpackage : tfs_pkg

// *** tfs_status.sv ***
// Status flag register bank with APB slave, pins and interrupt
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
module tfs_status
    import tfs_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        monitor_tick,
    input  wire logic [7:0]  local_temp,
    input  wire logic [7:0]  local_low_limit,
    input  wire logic [7:0]  local_high_limit,
    input  wire logic [7:0]  remote_temp_raw,
    input  wire logic [7:0]  remote_low_limit,
    input  wire logic [7:0]  remote_high_limit,
    input  wire logic [7:0]  remote_shutdown_limit,
    input  wire logic        remote_sensor_fault,
    input  wire logic [15:0] tachometer_count,
    input  wire logic [15:0] tachometer_count_low_limit,
    input  wire logic [15:0] tachometer_count_high_limit,
    input  wire logic        fan_spinning_up,
    input  wire logic        over_temp_pin_enable,
    output logic      [7:0]  remote_temp,
    output logic             thermal_shutdown_pin_n,
    output logic             over_temperature_pin_n,
    output logic             fan_fault_pin_n,
    output logic             alert_n,
    output logic             irq
);

    // ------------------------------------------------------------
    // State and comparisons
    // ------------------------------------------------------------
    tfs_state_s st;
    tfs_state_s next_st;

    logic       wr_acc;
    logic       rd_acc;
    logic       rd_status;
    logic       soft_rst;
    logic       remote_below_hyst;
    logic [7:0] hits;
    logic [7:0] next_stat;
    logic [7:0] next_rtemp;
    logic       slow_hit;
    logic       ovs_hit;
    logic       shut_hit;
    logic       sense_ie;
    logic       shut_ie;
    logic       fan_ie;
    logic [8:0] hyst_limit;

    assign wr_acc    = psel && penable && pwrite && st.pready;
    assign rd_acc    = psel && penable && !pwrite && st.pready;
    assign rd_status = rd_acc && (paddr == TFS_ADDR_STATUS);
    assign soft_rst  = wr_acc && (paddr == TFS_ADDR_CTRL) && pstrb[0]
                       && pwdata[TFS_CTRL_SOFT_RST];
    assign sense_ie  = st.ctrl[TFS_CTRL_SENSOR_IE];
    assign shut_ie   = st.ctrl[TFS_CTRL_SHUT_IE];
    assign fan_ie    = st.ctrl[TFS_CTRL_FAN_IE];

    // Shutdown limit minus hysteresis, signed compare
    assign hyst_limit        = {remote_shutdown_limit[7], remote_shutdown_limit}
                               - {1'b0, TFS_HYST_DEG};
    assign remote_below_hyst = $signed({next_rtemp[7], next_rtemp}) <= $signed(hyst_limit);

    assign slow_hit = monitor_tick && !fan_spinning_up
                      && (tachometer_count >= tachometer_count_low_limit);
    assign ovs_hit  = monitor_tick && (tachometer_count <= tachometer_count_high_limit);
    assign shut_hit = monitor_tick && ($signed(next_rtemp) > $signed(remote_shutdown_limit));

    always_comb begin
        next_rtemp = remote_sensor_fault ? TFS_FAIL_TEMP : remote_temp_raw;
        hits = 8'h00;
        hits[TFS_BIT_LOCAL_LOW]   = monitor_tick
            && ($signed(local_temp) <= $signed(local_low_limit));
        hits[TFS_BIT_LOCAL_HIGH]  = monitor_tick
            && ($signed(local_temp) >= $signed(local_high_limit));
        hits[TFS_BIT_SENSOR_FAIL] = remote_sensor_fault;
        hits[TFS_BIT_SHUTDOWN]    = shut_hit && st.shut_armed;
        hits[TFS_BIT_REMOTE_LOW]  = monitor_tick
            && ($signed(next_rtemp) <= $signed(remote_low_limit));
        hits[TFS_BIT_REMOTE_HIGH] = monitor_tick
            && ($signed(next_rtemp) >= $signed(remote_high_limit));
        hits[TFS_BIT_FAN_SLOW]    = slow_hit;
        hits[TFS_BIT_OVERSPEED]   = ovs_hit && st.ovs_armed;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_stat = st.status;
        // Read clears all but the sensor fail flag, a set wins
        if (rd_status) begin
            next_stat = st.status & (8'h01 << TFS_BIT_SENSOR_FAIL);
        end
        next_stat = next_stat | hits;
        next_st.status = next_stat;
        next_st.remote_temp = next_rtemp;

        // Shutdown rearm: armed again once remote is at or below limit minus 5
        if (rd_status && st.status[TFS_BIT_SHUTDOWN] && !hits[TFS_BIT_SHUTDOWN]) begin
            next_st.shut_armed = 1'b0;
        end else if (monitor_tick && remote_below_hyst) begin
            next_st.shut_armed = 1'b1;
        end

        // Overspeed rearm once speed drops below maximum
        if (rd_status && st.status[TFS_BIT_OVERSPEED] && !hits[TFS_BIT_OVERSPEED]) begin
            next_st.ovs_armed = 1'b0;
        end else if (monitor_tick && !ovs_hit) begin
            next_st.ovs_armed = 1'b1;
        end

        // Consecutive fan-slow counter
        if (monitor_tick && !fan_spinning_up) begin
            if (slow_hit) begin
                if (st.slow_cnt != TFS_FAIL_COUNT) begin
                    next_st.slow_cnt = st.slow_cnt + TFS_CNT_ONE;
                end
            end else begin
                next_st.slow_cnt = TFS_CNT_ZERO;
            end
        end
        next_st.fan_fail = (next_st.slow_cnt == TFS_FAIL_COUNT);

        // Interrupt pending: sticky, write one to clear, set wins
        if (wr_acc && (paddr == TFS_ADDR_IRQ) && pstrb[0]) begin
            next_st.irq_pend = st.irq_pend & ~pwdata[7:0];
        end
        next_st.irq_pend = next_st.irq_pend | hits;
        if (wr_acc && (paddr == TFS_ADDR_MASK) && pstrb[0]) begin
            next_st.irq_mask = pwdata[7:0];
        end
        if (wr_acc && (paddr == TFS_ADDR_CTRL) && pstrb[0]) begin
            next_st.ctrl = pwdata[2:0];
        end

        // Soft reset returns flags to zero
        if (soft_rst) begin
            next_st.status     = TFS_STATUS_RESET;
            next_st.shut_armed = 1'b1;
            next_st.ovs_armed  = 1'b1;
            next_st.slow_cnt   = TFS_CNT_ZERO;
            next_st.fan_fail   = 1'b0;
        end

        // Pins
        next_st.shutdown_n  = !next_st.status[TFS_BIT_SHUTDOWN];
        next_st.over_temp_n = !(over_temp_pin_enable
                                && next_st.status[TFS_BIT_SENSOR_FAIL]);
        next_st.fan_fault_n = !next_st.fan_fail;
        next_st.alert_n = !((sense_ie && next_st.status[TFS_BIT_SENSOR_FAIL])
            || (shut_ie && next_st.status[TFS_BIT_SHUTDOWN])
            || (fan_ie && next_st.status[TFS_BIT_FAN_SLOW])
            || (fan_ie && next_st.status[TFS_BIT_OVERSPEED]));
        next_st.irq = |(next_st.irq_pend & next_st.irq_mask);

        // APB: one wait state, answer in the second access cycle
        next_st.pready  = psel && penable && !st.pready;
        next_st.pslverr = 1'b0;
        next_st.prdata  = TFS_ZERO_WORD;
        if (psel && penable && !st.pready) begin
            unique case (paddr)
                TFS_ADDR_STATUS: begin
                    next_st.prdata[7:0] = st.status;
                    next_st.pslverr = pwrite;
                end
                TFS_ADDR_MASK:  next_st.prdata[7:0] = st.irq_mask;
                TFS_ADDR_IRQ:   next_st.prdata[7:0] = st.irq_pend;
                TFS_ADDR_CTRL:  next_st.prdata[2:0] = st.ctrl;
                TFS_ADDR_STATE: next_st.prdata[5:0] = {st.fan_fail, st.slow_cnt,
                                                       st.ovs_armed, st.shut_armed};
                default:        next_st.pslverr = 1'b1;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st             <= '0;
            st.status      <= TFS_STATUS_RESET;
            st.irq_mask    <= TFS_MASK_RESET;
            st.ctrl        <= TFS_CTRL_RESET;
            st.shut_armed  <= 1'b1;
            st.ovs_armed   <= 1'b1;
            st.shutdown_n  <= 1'b1;
            st.over_temp_n <= 1'b1;
            st.fan_fault_n <= 1'b1;
            st.alert_n     <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign prdata                 = st.prdata;
    assign pready                 = st.pready;
    assign pslverr                = st.pslverr;
    assign remote_temp            = st.remote_temp;
    assign thermal_shutdown_pin_n = st.shutdown_n;
    assign over_temperature_pin_n = st.over_temp_n;
    assign fan_fault_pin_n        = st.fan_fault_n;
    assign alert_n                = st.alert_n;
    assign irq                    = st.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_fail_sticky: assert property (
        st.status[TFS_BIT_SENSOR_FAIL] && !soft_rst |=> st.status[TFS_BIT_SENSOR_FAIL])
        else $error("sensor fail flag dropped");
    chk_fail_sets: assert property (
        remote_sensor_fault && !soft_rst |=> st.status[TFS_BIT_SENSOR_FAIL]
            && st.remote_temp == TFS_FAIL_TEMP)
        else $error("sensor fault not flagged");
    chk_read_clears: assert property (
        rd_status && hits == 8'h00 && !soft_rst |=>
            (st.status & ~(8'h01 << TFS_BIT_SENSOR_FAIL)) == 8'h00)
        else $error("read did not clear flags");
    chk_set_wins: assert property (
        rd_status && hits[TFS_BIT_LOCAL_LOW] && !soft_rst |=> st.status[TFS_BIT_LOCAL_LOW])
        else $error("set lost on read");
    chk_shut_pin: assert property (
        st.status[TFS_BIT_SHUTDOWN] |=> !thermal_shutdown_pin_n || $past(soft_rst)
            || $past(rd_status))
        else $error("shutdown pin not low");
    chk_shut_rearm: assert property (
        !st.shut_armed && shut_hit && !remote_below_hyst |=> !st.status[TFS_BIT_SHUTDOWN])
        else $error("shutdown flag rearmed early");
    chk_ovs_rearm: assert property (
        !st.ovs_armed && ovs_hit |=> !st.status[TFS_BIT_OVERSPEED] || $past(soft_rst))
        else $error("overspeed flag rearmed early");
    chk_fan_fail: assert property (
        slow_hit && st.slow_cnt == (TFS_FAIL_COUNT - TFS_CNT_ONE) && !soft_rst
            |=> !fan_fault_pin_n)
        else $error("fan fault pin not low");
    chk_spinup: assert property (
        fan_spinning_up && !st.status[TFS_BIT_FAN_SLOW] |=> !st.status[TFS_BIT_FAN_SLOW])
        else $error("slow detected in spin up");
    chk_alert_fan: assert property (
        st.status[TFS_BIT_FAN_SLOW] && fan_ie && !rd_status && !soft_rst
            && !$past(soft_rst) |=> !alert_n)
        else $error("fan alert missing");

    // ------------------------------------------------------------
    // Flag setting and clearing checks
    // ------------------------------------------------------------
    chk_local_low: assert property (
        monitor_tick && $signed(local_temp) <= $signed(local_low_limit) && !soft_rst
            |=> st.status[TFS_BIT_LOCAL_LOW])
        else $error("local low flag missing");
    chk_local_high: assert property (
        monitor_tick && $signed(local_temp) >= $signed(local_high_limit) && !soft_rst
            |=> st.status[TFS_BIT_LOCAL_HIGH])
        else $error("local high flag missing");
    chk_remote_low: assert property (
        monitor_tick && !remote_sensor_fault && !soft_rst
            && $signed(remote_temp_raw) <= $signed(remote_low_limit)
            |=> st.status[TFS_BIT_REMOTE_LOW])
        else $error("remote low flag missing");
    chk_remote_high: assert property (
        monitor_tick && !remote_sensor_fault && !soft_rst
            && $signed(remote_temp_raw) >= $signed(remote_high_limit)
            |=> st.status[TFS_BIT_REMOTE_HIGH])
        else $error("remote high flag missing");
    chk_shut_sets: assert property (
        shut_hit && st.shut_armed && !soft_rst
            |=> st.status[TFS_BIT_SHUTDOWN] && !thermal_shutdown_pin_n)
        else $error("shutdown flag missing");
    chk_slow_sets: assert property (
        monitor_tick && !fan_spinning_up && tachometer_count >= tachometer_count_low_limit && !soft_rst
            |=> st.status[TFS_BIT_FAN_SLOW])
        else $error("fan slow flag missing");
    chk_slow_clear: assert property (
        rd_status && !slow_hit |=> !st.status[TFS_BIT_FAN_SLOW])
        else $error("fan slow flag not cleared");
    chk_ovs_sets: assert property (
        monitor_tick && tachometer_count <= tachometer_count_high_limit && st.ovs_armed && !soft_rst
            |=> st.status[TFS_BIT_OVERSPEED])
        else $error("overspeed flag missing");
    chk_ovs_clear: assert property (
        rd_status && !ovs_hit |=> !st.status[TFS_BIT_OVERSPEED])
        else $error("overspeed flag not cleared");
    chk_soft_clear: assert property (
        soft_rst |=> st.status == TFS_STATUS_RESET)
        else $error("soft reset left flags");
    chk_pend_set: assert property (
        hits[TFS_BIT_LOCAL_LOW] |=> st.irq_pend[TFS_BIT_LOCAL_LOW])
        else $error("pending bit lost");

    // ------------------------------------------------------------
    // Pin and bus checks
    // ------------------------------------------------------------
    chk_over_pin: assert property (
        st.status[TFS_BIT_SENSOR_FAIL] && over_temp_pin_enable && !soft_rst
            |=> !over_temperature_pin_n)
        else $error("over temp pin not low");
    chk_temp_pass: assert property (
        !remote_sensor_fault |=> remote_temp == $past(remote_temp_raw))
        else $error("remote reading altered");
    chk_alert_fail: assert property (
        st.status[TFS_BIT_SENSOR_FAIL] && sense_ie && !soft_rst |=> !alert_n)
        else $error("sensor fail alert missing");
    chk_alert_off: assert property (
        !sense_ie && !shut_ie && !fan_ie |=> alert_n)
        else $error("alert without enable");
    chk_fault_pin: assert property (
        fan_fault_pin_n == (st.slow_cnt != TFS_FAIL_COUNT))
        else $error("fan fault pin wrong");
    chk_status_ro: assert property (
        wr_acc && paddr == TFS_ADDR_STATUS |-> pslverr)
        else $error("status write accepted");
    chk_ready_pulse: assert property (
        pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_irq_level: assert property (
        irq == |(st.irq_pend & st.irq_mask))
        else $error("interrupt level wrong");

    // ------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------
    cov_status_read: cover property (rd_status && st.status != 8'h00);
    cov_fan_fail:    cover property (!fan_fault_pin_n);
    cov_shut_rearm:  cover property (!st.shut_armed ##1 st.shut_armed);
    cov_alert_low:   cover property (!alert_n);
    cov_sensor_fail: cover property (st.status[TFS_BIT_SENSOR_FAIL]);

endmodule : tfs_status

// *** tfs_host.sv ***
// Host model: APB master issuing one transfer per request
`timescale 1ns/10ps
module tfs_host
    import tfs_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        go,
    input  wire logic        wr,
    input  wire logic [11:0] addr,
    input  wire logic [31:0] wdata,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    output logic      [3:0]  pstrb,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             done,
    output logic      [31:0] rdata,
    output logic             err
);
    assign pstrb = 4'hF;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psel    <= 1'b0;
            penable <= 1'b0;
            done    <= 1'b0;
            pwdata  <= 32'h0;
            pwrite  <= 1'b0;
            paddr   <= 12'h0;
            rdata   <= 32'h0;
            err     <= 1'b0;
        end else begin
            done <= 1'b0;
            if (psel && penable && pready) begin
                psel    <= 1'b0;
                penable <= 1'b0;
                done    <= 1'b1;
                rdata   <= prdata;
                err     <= pslverr;
                // Released data lines must not keep the old value
                pwdata  <= ~pwdata;
            end else if (psel) begin
                penable <= 1'b1;
            end else if (go) begin
                psel   <= 1'b1;
                pwrite <= wr;
                paddr  <= addr;
                pwdata <= wdata;
            end
        end
    end
endmodule : tfs_host

// *** test_tfs_status.sv ***
// Self-checking bench for the thermal and fan status flag block
`timescale 1ns/10ps
module test_tfs_status import tfs_pkg::*;;
    typedef struct packed {
        logic [7:0]  lt, ll, lh, rraw, rl, rh, rsl;
        logic [15:0] tc, tlo, thi;
        logic        spin, flt, ote;
    } tfs_stim_s;
    tfs_stim_s   v = '0, s = '0;
    logic        pclk = 1'b0, presetn = 1'b0, tick = 1'b0, go = 1'b0, wr = 1'b0;
    logic [11:0] addr = 12'h0, paddr;
    logic [31:0] wdata = 32'h0, pwdata, prdata, rdata;
    logic        psel, penable, pwrite, pready, pslverr, done, err, irq;
    logic [3:0]  pstrb;
    logic [7:0]  rtemp;
    logic        shut_n, ovr_n, ff_n, alert_n;
    int          n_fail = 0, compares = 0, cyc = 0, st = 0, ctl = 0, sc = 0;
    bit          sa = 1, oa = 1;

    always #50 pclk = ~pclk;

    tfs_host host (.pclk(pclk), .presetn(presetn), .go(go), .wr(wr), .addr(addr),
        .wdata(wdata), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .done(done), .rdata(rdata), .err(err));
    tfs_status dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .monitor_tick(tick), .local_temp(s.lt),
        .local_low_limit(s.ll), .local_high_limit(s.lh), .remote_temp_raw(s.rraw),
        .remote_low_limit(s.rl), .remote_high_limit(s.rh), .remote_shutdown_limit(s.rsl),
        .remote_sensor_fault(s.flt), .tachometer_count(s.tc), .tachometer_count_low_limit(s.tlo),
        .tachometer_count_high_limit(s.thi), .fan_spinning_up(s.spin), .over_temp_pin_enable(s.ote),
        .remote_temp(rtemp), .thermal_shutdown_pin_n(shut_n), .over_temperature_pin_n(ovr_n),
        .fan_fault_pin_n(ff_n), .alert_n(alert_n), .irq(irq));

    task automatic summarize;
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize

    // Hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            summarize;
        end
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic chkp(input string n, input logic e, input logic g);
        chk(n, 32'(e), 32'(g));
    endtask : chkp

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        {go, wr, addr, wdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        go <= 1'b0;
        do begin
            @(posedge pclk);
            #1;
            k++;
        end while (done !== 1'b1 && k < 20);
        if (k == 20) n_fail++;
    endtask : xfer

    // Reference flag model, one monitoring cycle
    task automatic model;
        int r;
        r = s.flt ? -128 : int'($signed(s.rraw));
        if ($signed(s.lt) <= $signed(s.ll)) st |= 8'h80;
        if ($signed(s.lt) >= $signed(s.lh)) st |= 8'h40;
        if (s.flt) st |= 8'h20;
        if (r > int'($signed(s.rsl)) && sa) st |= 8'h10;
        if (r <= int'($signed(s.rsl)) - 5) sa = 1;
        if (r <= int'($signed(s.rl))) st |= 8'h08;
        if (r >= int'($signed(s.rh))) st |= 8'h04;
        if (!s.spin && s.tc >= s.tlo) st |= 8'h02;
        if (!s.spin) sc = (s.tc < s.tlo) ? 0 : ((sc < 5) ? sc + 1 : 5);
        if (s.tc <= s.thi && oa) st |= 8'h01;
        if (s.tc > s.thi) oa = 1;
    endtask : model

    task automatic tk;
        logic a;
        @(posedge pclk);
        s <= v;
        tick <= 1'b1;
        @(posedge pclk);
        tick <= 1'b0;
        #1;
        model;
        a = !((st[5] && ctl[0]) || (st[4] && ctl[1]) || ((st[1] || st[0]) && ctl[2]));
        chkp("shutdown pin", !st[4], shut_n);
        chkp("over temp pin", !(st[5] && s.ote), ovr_n);
        chkp("fan fault pin", sc < 5, ff_n);
        chkp("alert", a, alert_n);
        chk("remote temp", 32'(s.flt ? 8'h80 : s.rraw), 32'(rtemp));
    endtask : tk

    task automatic rdst(input logic [7:0] m);
        xfer(1'b0, TFS_ADDR_STATUS, 32'h0);
        chk("status", 32'(st & m), rdata & 32'(m));
        if (st[4]) sa = 0;
        if (st[0]) oa = 0;
        st &= 32'h20;
    endtask : rdst

    task automatic wreg(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
        chkp("slave error", 1'b0, err);
        if (a == TFS_ADDR_CTRL) begin
            ctl = d[2:0];
            if (d[3]) {st, sc, sa, oa} = {32'h0, 32'h0, 2'b11};
        end
    endtask : wreg

    initial begin
        void'($urandom(16));
        v = '{8'h05, 8'h0A, 8'h14, 8'h3C, 8'h32, 8'h50, 8'h46, 16'h01F4, 16'h02BC,
              16'h012C, 1'b0, 1'b0, 1'b1};
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdst(8'hFF);
        xfer(1'b0, TFS_ADDR_MASK, 32'h0);
        chk("mask", 32'h000000FF, rdata);
        xfer(1'b0, 12'h0FC, 32'h0);
        chk("unmapped data", 32'h0, rdata);
        chkp("unmapped error", 1'b1, err);
        xfer(1'b1, TFS_ADDR_STATUS, 32'h000000FF);
        chkp("status write error", 1'b1, err);
        wreg(TFS_ADDR_MASK, 32'h0);
        wreg(TFS_ADDR_CTRL, 32'h7);
        tk;
        chkp("irq masked", 1'b0, irq);
        wreg(TFS_ADDR_MASK, 32'h000000FF);
        @(posedge pclk);
        #1;
        chkp("irq raised", 1'b1, irq);
        rdst(8'hFF);
        wreg(TFS_ADDR_IRQ, 32'h000000FF);
        @(posedge pclk);
        #1;
        chkp("irq cleared", 1'b0, irq);
        v.tc = 16'h0320;
        repeat (6) tk;
        rdst(8'hFF);
        {v.tc, v.rraw} = {16'h0064, 8'h4B};
        tk;
        rdst(8'hFF);
        tk;
        rdst(8'hFF);
        {v.tc, v.rraw} = {16'h01F4, 8'h41};
        tk;
        {v.tc, v.rraw} = {16'h0064, 8'h4B};
        tk;
        rdst(8'hFF);
        repeat (40) begin
            if ($urandom_range(0, 1)) begin
                v.lt = 8'($urandom_range(0, 30));
                v.rraw = 8'($urandom_range(40, 90));
                v.tc = 16'($urandom_range(100, 900));
                v.spin = ($urandom_range(0, 3) == 0);
                v.ote = 1'($urandom_range(0, 1));
            end
            tk;
            if ($urandom_range(0, 2) == 0) rdst(8'hFF);
            if ($urandom_range(0, 4) == 0) wreg(TFS_ADDR_CTRL, 32'($urandom_range(0, 7)));
        end
        v.flt = 1'b1;
        tk;
        rdst(8'h20);
        v.flt = 1'b0;
        tk;
        rdst(8'h20);
        wreg(TFS_ADDR_CTRL, 32'h8);
        rdst(8'hFF);
        summarize;
    end
endmodule : test_tfs_status
